// ===== pkg/eetw_pkg.sv
/*
  Shared constants of the two-wire EEPROM access link: timing, slave byte
  layout, control register bits and the host command port map.
  Assumes a 20 MHz system clock on both ends.
*/
package eetw_pkg;
  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int CLK_MHZ = 20;
  localparam int WC_TYP_US = 5000;
  localparam int WC_CYCLES = WC_TYP_US * CLK_MHZ;
  localparam int POR_NS = 2000;
  localparam int POR_CYCLES = (POR_NS * CLK_MHZ + 999) / 1000;
  localparam int SCL_QTR_NS = 625;
  localparam int SCL_QTR_CYCLES = (SCL_QTR_NS * CLK_MHZ + 999) / 1000;

  // ----------------------------------------
  // Array and slave byte
  // ----------------------------------------
  localparam int ADDR_W = 11;
  localparam int PAGE_W = 6;
  // Device type field; value is arbitrary
  localparam logic [3:0] DEV_TYPE = 4'h6;
  localparam logic RW_READ = 1'b1;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [3:0] SLOT_END = 4'h9;
  localparam logic [15:0] CTRL_WADDR = 16'hFFFF;

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  localparam logic [7:0] CTRL_SET_WR_EN = 8'h02;
  localparam logic [7:0] CTRL_SET_REG_WR = 8'h06;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int CB_HW_PROT_EN = 7;
  localparam int CB_WD1 = 6;
  localparam int CB_WD0 = 5;
  localparam int CB_BP2 = 4;
  localparam int CB_BP1 = 3;
  localparam int CB_REG_WR_LATCH = 2;
  localparam int CB_WR_EN_LATCH = 1;
  localparam int CB_BP0 = 0;

  // ----------------------------------------
  // Host command port
  // ----------------------------------------
  localparam logic [3:0] HREG_CMD = 4'h0;
  localparam logic [3:0] HREG_TX = 4'h4;
  localparam logic [3:0] HREG_STAT = 4'h8;
  localparam logic [3:0] HREG_RX = 4'hC;
  localparam logic [1:0] CMD_START = 2'h0;
  localparam logic [1:0] CMD_STOP = 2'h1;
  localparam logic [1:0] CMD_WRITE = 2'h2;
  localparam logic [1:0] CMD_READ = 2'h3;
  localparam int CMD_NACK_BIT = 2;
endpackage

// ===== pkg/eetw_link_if.sv
/*
  Two-wire link between bus master and EEPROM slave.
  SCL is driven by the master only; SDA is open drain, resolved here
  from both output enables.
*/
`timescale 1ns/1ps
interface eetw_link_if;
  logic scl;
  logic h_sda_o;
  logic h_sda_oe;
  logic d_sda_o;
  logic d_sda_oe;
  logic sda;

  assign sda = !((h_sda_oe && !h_sda_o) || (d_sda_oe && !d_sda_o));

  modport host(output scl, output h_sda_o, output h_sda_oe, input sda);
  modport dev(input scl, input sda, output d_sda_o, output d_sda_oe);
endinterface

// ===== hw/eetw_sync.sv
/*
  Two flip-flop synchroniser for a vector of independent levels.
  Assumes each bit is a slow level; no bus coherency is given.
*/
`timescale 1ns/1ps
module eetw_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= '1;
      q_o <= '1;
    end else begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule

// ===== hw/eetw_dev.sv
/*
  EEPROM slave end of the two-wire link: slave byte decode, word address,
  array and control register writes, reads with address counter.
  Assumes SCL and SDA come from another domain and are oversampled by
  clk_i; SCL must stay low and high for at least four clk_i cycles.
*/
// Summary of operation
// - Withhold slave ack while write cycle runs
// - Master polls with start and slave byte
// - Last slave bit one reads, zero writes
// - Address counter holds last read plus one
// - Counter zero after reset until an address is loaded
// - Read slave byte acked, then eight bits out
// - Master ends read with nack then stop
// - Random read: dummy write, repeated start, read
// - Stop after word address only loads counter
// - Each master ack yields the next byte
// - Read counter wraps whole array to zero
// - Slave byte: type, zero, select, direction
// - Ack only on full slave byte match
// - Power up idle, latch cleared, SDA released
// - Writes refused without write enable latch
// - Write starts only after complete byte
// - Control bits need three-step sequence
// - Protect pin plus enable bit block control
// - Supervisor reset aborts and ignores bus
// - Locked blocks refuse writes
// - Ack allowed write bytes only, not bad slave
// - Sequence 02H, 06H, then value byte
`timescale 1ns/1ps
module eetw_dev #(
  parameter int WC_CYCLES = eetw_pkg::WC_CYCLES,
  parameter int POR_CYCLES = eetw_pkg::POR_CYCLES,
  parameter int ADDR_W = eetw_pkg::ADDR_W,
  parameter int PAGE_W = eetw_pkg::PAGE_W
) (
  input wire logic clk_i,
  input wire logic rst_i,
  eetw_link_if.dev link,
  input wire logic [1:0] dev_sel_i,
  input wire logic wp_i,
  output logic reset_o,
  output logic busy_o,
  output logic [7:0] ctrl_o
);
  localparam int PAGE = 2 ** PAGE_W;
  localparam int WC_W = $clog2(WC_CYCLES + 1);
  localparam int POR_W = $clog2(POR_CYCLES + 1);

  if (PAGE_W >= ADDR_W || WC_CYCLES < 1 || POR_CYCLES < 1) begin : g_bad_param
    $error("eetw_dev: unsupported parameter values");
  end

  typedef enum logic [2:0] {S_IDLE, S_DEV, S_AHI, S_ALO, S_WR, S_RD} eetw_dstate_t;

  // ----------------------------------------
  // Pin sampling
  // ----------------------------------------
  logic scl_s, sda_s, wp_s, scl_p, sda_p;
  logic [1:0] sel_s;

  eetw_sync #(.W(5)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({link.scl, link.sda, wp_i, dev_sel_i}),
    .q_o({scl_s, sda_s, wp_s, sel_s})
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scl_p <= 1'b1;
      sda_p <= 1'b1;
    end else begin
      scl_p <= scl_s;
      sda_p <= sda_s;
    end
  end

  wire start_w = scl_s && scl_p && sda_p && !sda_s;
  wire stop_w = scl_s && scl_p && !sda_p && sda_s;
  wire rise_w = scl_s && !scl_p;
  wire fall_w = !scl_s && scl_p;

  // ----------------------------------------
  // Power-on supervisor reset
  // ----------------------------------------
  logic [POR_W-1:0] por_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      por_q <= '0;
      reset_o <= 1'b1;
    end else if (reset_o) begin
      por_q <= por_q + POR_W'(1);
      reset_o <= (por_q != POR_W'(POR_CYCLES - 1));
    end
  end

  // ----------------------------------------
  // Block lock decode
  // ----------------------------------------
  function automatic logic locked_f(input logic [ADDR_W-1:0] a, input logic [2:0] bp);
    logic [ADDR_W:0] span;
    span = '0;
    case (bp)
      3'h1: span = (ADDR_W+1)'(PAGE);
      3'h2: span = (ADDR_W+1)'(2 * PAGE);
      3'h3: span = (ADDR_W+1)'(4 * PAGE);
      3'h4: span = (ADDR_W+1)'(8 * PAGE);
      3'h5: span = (ADDR_W+1)'(2 ** ADDR_W);
      default: span = '0;
    endcase
    return (span != '0) && ({1'b0, a} >= (ADDR_W+1)'(2 ** ADDR_W) - span);
  endfunction

  // ----------------------------------------
  // Protocol engine
  // ----------------------------------------
  eetw_dstate_t st_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q, tx_q, whi_q;
  logic mack_q, done_q, got_q, ctl_q;
  logic [ADDR_W-1:0] addr_q;
  logic [WC_W-1:0] wc_q;
  logic [7:0] mem_q [2**ADDR_W];
  logic [7:0] buf_q [PAGE];
  logic [PAGE-1:0] mask_q;
  logic [15:0] waddr_w;
  logic [2:0] bp_w;

  assign waddr_w = {whi_q, sh_q};
  assign bp_w = {ctrl_o[eetw_pkg::CB_BP2], ctrl_o[eetw_pkg::CB_BP1], ctrl_o[eetw_pkg::CB_BP0]};
  assign link.d_sda_o = 1'b0;

  always_ff @(posedge clk_i) begin
    if (rst_i || reset_o) begin
      st_q <= S_IDLE;
      cnt_q <= '0;
      link.d_sda_oe <= 1'b0;
      sh_q <= '0;
      tx_q <= '0;
      whi_q <= '0;
      mack_q <= 1'b0;
      done_q <= 1'b0;
      got_q <= 1'b0;
      ctl_q <= 1'b0;
      addr_q <= '0;
      mask_q <= '0;
      wc_q <= '0;
      busy_o <= 1'b0;
      if (rst_i) begin
        ctrl_o <= eetw_pkg::CTRL_RESET;
      end
    end else begin
      if (wc_q != '0) begin
        wc_q <= wc_q - WC_W'(1);
        busy_o <= (wc_q != WC_W'(1));
      end
      if (start_w) begin
        st_q <= S_DEV;
        cnt_q <= '0;
        link.d_sda_oe <= 1'b0;
      end else if (stop_w) begin
        st_q <= S_IDLE;
        link.d_sda_oe <= 1'b0;
        if (st_q == S_WR && done_q && got_q) begin
          if (ctl_q) begin
            if (ctrl_o[eetw_pkg::CB_REG_WR_LATCH] && tx_q[eetw_pkg::CB_WR_EN_LATCH]
                && !tx_q[eetw_pkg::CB_REG_WR_LATCH]) begin
              ctrl_o <= tx_q;
              ctrl_o[eetw_pkg::CB_REG_WR_LATCH] <= 1'b0;
              ctrl_o[eetw_pkg::CB_WR_EN_LATCH] <= 1'b1;
              wc_q <= WC_W'(WC_CYCLES);
              busy_o <= 1'b1;
            end else if (tx_q == eetw_pkg::CTRL_SET_WR_EN) begin
              ctrl_o[eetw_pkg::CB_WR_EN_LATCH] <= 1'b1;
            end else if (tx_q == eetw_pkg::CTRL_SET_REG_WR
                         && ctrl_o[eetw_pkg::CB_WR_EN_LATCH]) begin
              ctrl_o[eetw_pkg::CB_REG_WR_LATCH] <= 1'b1;
            end
          end else begin
            for (int i = 0; i < PAGE; i++) begin
              if (mask_q[i]) begin
                mem_q[{addr_q[ADDR_W-1:PAGE_W], PAGE_W'(i)}] <= buf_q[i];
              end
            end
            wc_q <= WC_W'(WC_CYCLES);
            busy_o <= 1'b1;
          end
        end
      end else if (st_q != S_IDLE && rise_w) begin
        if (cnt_q < eetw_pkg::ACK_SLOT) begin
          sh_q <= {sh_q[6:0], sda_s};
        end else begin
          // Own ack after the read slave byte also reads as a master ack
          mack_q <= !sda_s;
        end
        cnt_q <= cnt_q + 4'h1;
      end else if (st_q != S_IDLE && fall_w) begin
        if (cnt_q == eetw_pkg::ACK_SLOT) begin
          link.d_sda_oe <= 1'b1;
          case (st_q)
            S_DEV: begin
              if (sh_q[7:1] != {eetw_pkg::DEV_TYPE, 1'b0, sel_s} || busy_o) begin
                link.d_sda_oe <= 1'b0;
                st_q <= S_IDLE;
              end else begin
                st_q <= (sh_q[0] == eetw_pkg::RW_READ) ? S_RD : S_AHI;
              end
            end
            S_AHI: begin
              whi_q <= sh_q;
              st_q <= S_ALO;
            end
            S_ALO: begin
              addr_q <= waddr_w[ADDR_W-1:0];
              ctl_q <= (waddr_w == eetw_pkg::CTRL_WADDR);
              got_q <= 1'b0;
              mask_q <= '0;
              st_q <= S_WR;
            end
            S_WR: begin
              if (ctl_q) begin
                if (got_q || (wp_s && ctrl_o[eetw_pkg::CB_HW_PROT_EN])) begin
                  link.d_sda_oe <= 1'b0;
                  st_q <= S_IDLE;
                end else begin
                  tx_q <= sh_q;
                  got_q <= 1'b1;
                end
              end else if (!ctrl_o[eetw_pkg::CB_WR_EN_LATCH]) begin
                link.d_sda_oe <= 1'b0;
                st_q <= S_IDLE;
              end else if (locked_f(addr_q, bp_w)) begin
                link.d_sda_oe <= 1'b0;
                ctrl_o[eetw_pkg::CB_REG_WR_LATCH] <= 1'b0;
                st_q <= S_IDLE;
              end else begin
                buf_q[addr_q[PAGE_W-1:0]] <= sh_q;
                mask_q[addr_q[PAGE_W-1:0]] <= 1'b1;
                addr_q[PAGE_W-1:0] <= addr_q[PAGE_W-1:0] + PAGE_W'(1);
                got_q <= 1'b1;
              end
            end
            default: link.d_sda_oe <= 1'b0;
          endcase
        end else if (cnt_q == eetw_pkg::SLOT_END) begin
          cnt_q <= '0;
          link.d_sda_oe <= 1'b0;
          if (st_q == S_WR) begin
            done_q <= 1'b1;
          end
          if (st_q == S_RD) begin
            if (mack_q) begin
              tx_q <= mem_q[addr_q];
              link.d_sda_oe <= !mem_q[addr_q][7];
              addr_q <= addr_q + ADDR_W'(1);
            end else begin
              st_q <= S_IDLE;
            end
          end
        end else begin
          done_q <= 1'b0;
          if (st_q == S_RD) begin
            tx_q <= {tx_q[6:0], 1'b1};
            link.d_sda_oe <= !tx_q[6];
          end
        end
      end
    end
  end
endmodule

// ===== hw/eetw_host.sv
/*
  Two-wire bus master: software issues start, stop, byte write and byte
  read commands through a small register port.
  Assumes one slave on the link that never stretches SCL.
*/
`timescale 1ns/1ps
module eetw_host #(
  parameter int QTR_CYCLES = eetw_pkg::SCL_QTR_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  eetw_link_if.host link
);
  localparam int QW = $clog2(QTR_CYCLES + 1);

  if (QTR_CYCLES < 4) begin : g_bad_param
    $error("eetw_host: SCL quarter period too short for the slave");
  end

  typedef enum logic [1:0] {H_IDLE, H_START, H_BITS, H_STOP} eetw_hstate_t;

  logic sda_s;

  eetw_sync #(.W(1)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(link.sda),
    .q_o(sda_s)
  );

  eetw_hstate_t st_q;
  logic [QW-1:0] qc_q;
  logic [1:0] ph_q;
  logic [3:0] bit_q;
  logic [8:0] sh_q, rx_q;
  logic [7:0] tx_q;
  wire go_w = wr_i && addr_i == eetw_pkg::HREG_CMD && st_q == H_IDLE;

  assign link.h_sda_o = 1'b0;

  // ----------------------------------------
  // Register port
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_q <= '0;
      rdata_o <= '0;
    end else begin
      if (wr_i && addr_i == eetw_pkg::HREG_TX) begin
        tx_q <= wdata_i;
      end
      if (rd_i) begin
        case (addr_i)
          eetw_pkg::HREG_STAT: rdata_o <= {6'h00, st_q != H_IDLE, rx_q[0]};
          eetw_pkg::HREG_RX: rdata_o <= rx_q[8:1];
          default: rdata_o <= 8'h00;
        endcase
      end else begin
        rdata_o <= 8'h00;
      end
    end
  end

  // ----------------------------------------
  // Bit engine: four quarter phases per step
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= H_IDLE;
      qc_q <= '0;
      ph_q <= '0;
      bit_q <= '0;
      sh_q <= '1;
      rx_q <= '0;
      link.scl <= 1'b1;
      link.h_sda_oe <= 1'b0;
    end else if (go_w) begin
      qc_q <= '0;
      ph_q <= '0;
      bit_q <= '0;
      case (wdata_i[1:0])
        eetw_pkg::CMD_START: st_q <= H_START;
        eetw_pkg::CMD_STOP: st_q <= H_STOP;
        eetw_pkg::CMD_WRITE: begin
          st_q <= H_BITS;
          sh_q <= {tx_q, 1'b1};
        end
        default: begin
          st_q <= H_BITS;
          sh_q <= {8'hFF, wdata_i[eetw_pkg::CMD_NACK_BIT]};
        end
      endcase
    end else if (st_q != H_IDLE) begin
      if (qc_q != QW'(QTR_CYCLES - 1)) begin
        qc_q <= qc_q + QW'(1);
      end else begin
        qc_q <= '0;
        ph_q <= ph_q + 2'h1;
        case (st_q)
          H_START: begin
            case (ph_q)
              2'h0: link.h_sda_oe <= 1'b0;
              2'h1: link.scl <= 1'b1;
              2'h2: link.h_sda_oe <= 1'b1;
              default: begin
                link.scl <= 1'b0;
                st_q <= H_IDLE;
              end
            endcase
          end
          H_BITS: begin
            case (ph_q)
              2'h0: link.h_sda_oe <= !sh_q[8];
              2'h1: link.scl <= 1'b1;
              2'h2: rx_q <= {rx_q[7:0], sda_s};
              default: begin
                link.scl <= 1'b0;
                sh_q <= {sh_q[7:0], 1'b1};
                bit_q <= bit_q + 4'h1;
                if (bit_q == eetw_pkg::ACK_SLOT) begin
                  st_q <= H_IDLE;
                end
              end
            endcase
          end
          H_STOP: begin
            case (ph_q)
              2'h0: link.h_sda_oe <= 1'b1;
              2'h1: link.scl <= 1'b1;
              2'h2: link.h_sda_oe <= 1'b0;
              default: st_q <= H_IDLE;
            endcase
          end
          default: st_q <= H_IDLE;
        endcase
      end
    end
  end
endmodule

// ===== tb/eetw_assertions.sv
/*
  Checker of the two-wire link, watching the device end of the interface.
  Assumes one clock domain with a synchronous active-high reset.
*/
`timescale 1ns/1ps
module eetw_assertions #(
  parameter int WC_CYCLES = 1000,
  parameter int POR_CYCLES = 40
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic scl,
  input wire logic sda,
  input wire logic d_sda_o,
  input wire logic d_sda_oe,
  input wire logic reset_o,
  input wire logic busy_o
);
  int por_q;
  int wc_q;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ----------------------------------------
  // Counters
  // ----------------------------------------
  // One cycle of slack either way: the exact edge depends on register staging
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      por_q <= 0;
    end else if (reset_o) begin
      por_q <= por_q + 1;
    end
  end

  always_ff @(posedge clk_i) begin
    wc_q <= busy_o ? wc_q + 1 : 0;
  end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  sequence s_fall_seen;
    ##[1:64] $fell(scl);
  endsequence

  property p_sda_od;
    d_sda_oe |-> !d_sda_o && !sda;
  endproperty
  property p_reset_quiet;
    reset_o |-> !d_sda_oe;
  endproperty
  property p_por_len;
    $fell(reset_o) |-> por_q >= POR_CYCLES - 1 && por_q <= POR_CYCLES + 1;
  endproperty
  property p_busy_quiet;
    busy_o |-> !d_sda_oe;
  endproperty
  property p_busy_len;
    $fell(busy_o) |-> wc_q >= WC_CYCLES - 1 && wc_q <= WC_CYCLES + 1;
  endproperty
  property p_change_low;
    $changed(d_sda_oe) |-> !scl;
  endproperty
  property p_launch;
    $rose(d_sda_oe) |-> !scl && !$past(scl, 2);
  endproperty
  property p_hold;
    $rose(d_sda_oe) |-> d_sda_oe throughout s_fall_seen;
  endproperty
  property p_busy_after_stop;
    $rose(busy_o) |-> scl && sda;
  endproperty

  a_sda_od: assert property (p_sda_od) else $error("device drives sda high");
  a_reset_quiet: assert property (p_reset_quiet) else $error("sda driven in reset");
  a_por_len: assert property (p_por_len) else $error("reset output length wrong");
  a_busy_quiet: assert property (p_busy_quiet) else $error("ack while busy");
  a_busy_len: assert property (p_busy_len) else $error("write cycle length wrong");
  a_change_low: assert property (p_change_low) else $error("sda moved with scl high");
  a_launch: assert property (p_launch) else $error("sda launched too early");
  a_hold: assert property (p_hold) else $error("sda not held to scl fall");
  a_busy_after_stop: assert property (p_busy_after_stop) else $error("write not at stop");
endmodule

// ===== tb/eeprom_two_wire_read_access_test.sv
/*
  Testbench of the two-wire link: host and device joined by the interface,
  software steps driven through the host register port.
  Assumes the package, interface and both ends are compiled before it.
*/
`timescale 1ns/1ps
module eeprom_two_wire_read_access_test;
  localparam int WC = 1000;
  localparam logic [1:0] SEL = 2'h2;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic wp = 1'b0;
  logic chk = 1'b0;
  logic mon = 1'b0;
  logic [7:0] rdata;
  logic reset_o;
  logic busy_o;
  logic [7:0] ctrl;
  logic [15:0] e;
  logic [15:0] expq[$];
  logic [31:0] rng = 32'hE29D0E31;
  int fails = 0;
  int samples_checked = 0;

  initial forever #25 clk = ~clk;

  eetw_link_if link();
  eetw_host #(.QTR_CYCLES(4)) i_eetw_host(.clk_i(clk), .rst_i(rst), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .link(link.host));
  eetw_dev #(.WC_CYCLES(WC)) i_eetw_dev(.clk_i(clk), .rst_i(rst), .link(link.dev),
    .dev_sel_i(SEL), .wp_i(wp), .reset_o(reset_o), .busy_o(busy_o), .ctrl_o(ctrl));
  eetw_assertions #(.WC_CYCLES(WC), .POR_CYCLES(eetw_pkg::POR_CYCLES)) i_chk(.clk_i(clk),
    .rst_i(rst), .scl(link.scl), .sda(link.sda), .d_sda_o(link.d_sda_o),
    .d_sda_oe(link.d_sda_oe), .reset_o(reset_o), .busy_o(busy_o));

  // ----------------------------------------
  // Reporting and comparison
  // ----------------------------------------
  task automatic results();
    if (fails == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Read data stand only in the cycle after the strobe
  always @(posedge clk) mon <= rd && chk;
  always @(negedge clk) begin
    if (mon) begin
      e = expq.pop_front();
      cmp("rdata", e[7:0] & e[15:8], rdata & e[15:8]);
    end
  end

  function automatic logic [7:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng[7:0];
  endfunction

  function automatic logic [7:0] sb(input logic rw);
    return {eetw_pkg::DEV_TYPE, 1'b0, SEL, rw};
  endfunction

  // ----------------------------------------
  // Register port and link steps
  // ----------------------------------------
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d, input logic c);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    chk <= c;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    chk <= 1'b0;
  endtask

  task automatic cmd(input logic [7:0] c);
    int n;
    bus(1'b1, eetw_pkg::HREG_CMD, c, 1'b0);
    for (n = 0; n < 300; n++) begin
      bus(1'b0, eetw_pkg::HREG_STAT, 8'h00, 1'b0);
      @(negedge clk);
      if (rdata[1] === 1'b0) break;
    end
    if (n == 300) begin
      fails++;
      results();
    end
  endtask

  task automatic tx(input logic [7:0] b, input logic nack);
    bus(1'b1, eetw_pkg::HREG_TX, b, 1'b0);
    cmd({6'h00, eetw_pkg::CMD_WRITE});
    expq.push_back({8'h01, 7'h00, nack});
    bus(1'b0, eetw_pkg::HREG_STAT, 8'h00, 1'b1);
  endtask

  task automatic rx(input logic nack, input logic [7:0] v);
    cmd({5'h00, nack, eetw_pkg::CMD_READ});
    expq.push_back({8'hFF, v});
    bus(1'b0, eetw_pkg::HREG_RX, 8'h00, 1'b1);
  endtask

  task automatic start(input logic rw, input logic nack);
    cmd({6'h00, eetw_pkg::CMD_START});
    tx(sb(rw), nack);
  endtask

  task automatic stop();
    cmd({6'h00, eetw_pkg::CMD_STOP});
  endtask

  task automatic setaddr(input logic [15:0] a);
    start(1'b0, 1'b0);
    tx(a[15:8], 1'b0);
    tx(a[7:0], 1'b0);
  endtask

  // Acknowledge polling; the first probe follows the stop at once
  task automatic wait_idle();
    int n;
    for (n = 0; n < 40; n++) begin
      cmd({6'h00, eetw_pkg::CMD_START});
      bus(1'b1, eetw_pkg::HREG_TX, sb(1'b0), 1'b0);
      cmd({6'h00, eetw_pkg::CMD_WRITE});
      bus(1'b0, eetw_pkg::HREG_STAT, 8'h00, 1'b0);
      @(negedge clk);
      if (n == 0) cmp("first poll", 8'h01, {7'h00, rdata[0]});
      if (rdata[0] === 1'b0) break;
    end
    stop();
    if (n == 40) begin
      fails++;
      results();
    end
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    fails++;
    results();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    int i;
    logic [7:0] d [3];
    logic [7:0] bad [4];
    bad = '{8'h11, 8'h08, 8'h04, 8'h10};
    for (i = 0; i < 3; i++) d[i] = rnd();
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    cmp("ctrl", 8'h00, ctrl);
    for (i = 0; i < 200 && reset_o !== 1'b0; i++) @(posedge clk);
    cmp("reset", 8'h00, {7'h00, reset_o});
    setaddr(16'h0000);
    tx(rnd(), 1'b1);
    stop();
    cmp("busy", 8'h00, {7'h00, busy_o});
    for (i = 0; i < 4; i++) begin
      cmd({6'h00, eetw_pkg::CMD_START});
      tx(sb(1'b0) ^ bad[i], 1'b1);
      stop();
    end
    setaddr(eetw_pkg::CTRL_WADDR);
    tx(eetw_pkg::CTRL_SET_WR_EN, 1'b0);
    stop();
    cmp("ctrl", 8'h02, ctrl);
    setaddr(eetw_pkg::CTRL_WADDR);
    tx(eetw_pkg::CTRL_SET_REG_WR, 1'b0);
    stop();
    cmp("ctrl", 8'h06, ctrl);
    setaddr(eetw_pkg::CTRL_WADDR);
    tx(8'h02, 1'b0);
    stop();
    wait_idle();
    cmp("ctrl", 8'h02, ctrl);
    setaddr(16'h07FE);
    tx(d[0], 1'b0);
    tx(d[1], 1'b0);
    stop();
    wait_idle();
    setaddr(16'h0000);
    tx(d[2], 1'b0);
    tx(d[0], 1'b0);
    stop();
    wait_idle();
    setaddr(16'h07FE);
    start(1'b1, 1'b0);
    rx(1'b0, d[0]);
    rx(1'b0, d[1]);
    rx(1'b1, d[2]);
    stop();
    start(1'b1, 1'b0);
    rx(1'b1, d[0]);
    stop();
    setaddr(16'h07FF);
    stop();
    cmp("busy", 8'h00, {7'h00, busy_o});
    start(1'b1, 1'b0);
    rx(1'b1, d[1]);
    stop();
    start(1'b1, 1'b0);
    rx(1'b1, d[2]);
    stop();
    setaddr(eetw_pkg::CTRL_WADDR);
    tx(eetw_pkg::CTRL_SET_REG_WR, 1'b0);
    stop();
    setaddr(eetw_pkg::CTRL_WADDR);
    tx(8'h83, 1'b0);
    stop();
    wait_idle();
    cmp("ctrl", 8'h83, ctrl);
    setaddr(16'h07C0);
    tx(rnd(), 1'b1);
    stop();
    cmp("busy", 8'h00, {7'h00, busy_o});
    @(posedge clk);
    wp <= 1'b1;
    setaddr(eetw_pkg::CTRL_WADDR);
    tx(eetw_pkg::CTRL_SET_WR_EN, 1'b1);
    stop();
    cmp("ctrl", 8'h83, ctrl);
    results();
  end
endmodule
